/* verilog/mdl_datapath.sv */
// MII datapath latency model with an AXI4-Lite register slave
// Functional notes
// R1: Transmit start appears 5 bits after sampling edge
// R2: One-step timestamping makes transmit latency 9 bits
// R3: Control frames add 8 bits per depth unit
// R4: Transmit end appears 5 bits after deassert edge
// R5: Carrier on 20 bits TX, 10 bits FX
// R6: Receive data latency 24 bits TX, 14 FX
// R7: Receive timestamp insertion adds 40 bits latency
// R8: Status frames may delay received data
// R9: Carrier off 24 bits TX, 14 bits FX
// R10: Clock source switch never shortens a phase
// R11: At 10 Mb/s sample transmit on falling edge
// R12: 100 Mb/s bit time is 10 ns
// R13: 10 Mb/s bit time is 100 ns
// R14: 10BASE-T transmit starts 3.5 bits after edge
// R15: 10BASE-T end of packet held high 300 ns
// R16: 10BASE-T carrier on 630 ns after activity
// R17: 10BASE-T receive valid 10 bits after preamble
// R18: 10BASE-T receive data 8 bits latency
// R19: 10BASE-T carrier off within 1 us
// R20: Latency increments add, applied between frames
//
// Implementation choices: the AXI4-Lite slave port and the placing of the registers.
module mdl_datapath
  import mdl_pkg::*;
(
  input wire logic clk_in, // System clock, 100 MHz
  input wire logic rst_in, // Synchronous reset, active high
  input wire logic [ADDR_W-1:0] awaddr_in, // Write address
  input wire logic awvalid_in, // Write address valid
  output logic awready_out, // Write address ready
  input wire logic [31:0] wdata_in, // Write data
  input wire logic [3:0] wstrb_in, // Write byte strobes
  input wire logic wvalid_in, // Write data valid
  output logic wready_out, // Write data ready
  output logic [1:0] bresp_out, // Write response
  output logic bvalid_out, // Write response valid
  input wire logic bready_in, // Write response ready
  input wire logic [ADDR_W-1:0] araddr_in, // Read address
  input wire logic arvalid_in, // Read address valid
  output logic arready_out, // Read address ready
  output logic [31:0] rdata_out, // Read data
  output logic [1:0] rresp_out, // Read response
  output logic rvalid_out, // Read data valid
  input wire logic rready_in, // Read data ready
  input wire logic tx_clk_in, // MII transmit clock
  input wire logic tx_en_in, // MII transmit enable
  input wire logic [3:0] txd_in, // MII transmit nibble
  output logic rx_clk_out, // MII receive clock
  output logic rx_dv_out, // MII receive data valid
  output logic [3:0] rxd_out, // MII receive nibble
  output logic crs_out, // MII carrier sense
  output logic md_tx_en_out, // Medium transmit active
  output logic [3:0] md_txd_out, // Medium transmit nibble
  output logic md_tx_eop_out, // Medium end-of-packet high hold
  input wire logic md_rx_act_in, // Medium receive activity
  input wire logic [3:0] md_rxd_in, // Medium receive nibble
  input wire logic rec_lock_in // Recovered clock available
);
  logic [31:0] ctrl;
  logic aw_got, w_got;
  logic [ADDR_W-1:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic wr_fire;
  logic [5:0] tx_s, rx_s;
  logic tclk_d, tx_edge;
  logic [4:0] tx_hold, tx_q0;
  logic [4:0] rx_q0, rx_q1;
  logic crs_on_q, crs_off_q;
  logic act_d;
  logic [LAT_W-1:0] tx_lat, rx_lat, dv_lat, on_lat, off_lat;
  logic [LAT_W-1:0] next_tx_lat, next_rx_lat, next_dv_lat;
  logic [LAT_W-1:0] next_on_lat, next_off_lat;
  logic [LAT_W-1:0] rx_extra;
  logic tx_quiet, rx_quiet;
  logic [5:0] eop_cnt;
  logic stat_pend;
  logic [6:0] stat_cnt;
  mdl_rxs_t rx_st;
  logic [4:0] ph_cnt, half_cur;
  logic src_rec;
  logic spd10, fx;

  assign spd10 = ctrl[CTRL_SPD10];
  assign fx = ctrl[CTRL_FX];
  assign wr_fire = aw_got && w_got && !bvalid_out;

  // Write address channel; taken in any order with data
  always_ff @(posedge clk_in)
  begin
    if (rst_in)
    begin
      awready_out <= 1'b0;
      aw_got <= 1'b0;
      aw_addr <= '0;
    end
    else if (awready_out && awvalid_in)
    begin
      awready_out <= 1'b0;
      aw_got <= 1'b1;
      aw_addr <= awaddr_in;
    end
    else if (bvalid_out && bready_in)
      aw_got <= 1'b0;
    else if (!aw_got && !bvalid_out)
      awready_out <= 1'b1;
  end

  // Write data channel
  always_ff @(posedge clk_in)
  begin
    if (rst_in)
    begin
      wready_out <= 1'b0;
      w_got <= 1'b0;
      w_data <= '0;
      w_strb <= '0;
    end
    else if (wready_out && wvalid_in)
    begin
      wready_out <= 1'b0;
      w_got <= 1'b1;
      w_data <= wdata_in;
      w_strb <= wstrb_in;
    end
    else if (bvalid_out && bready_in)
      w_got <= 1'b0;
    else if (!w_got && !bvalid_out)
      wready_out <= 1'b1;
  end

  // Write response follows both halves
  always_ff @(posedge clk_in)
  begin
    if (rst_in)
    begin
      bvalid_out <= 1'b0;
      bresp_out <= RESP_OKAY;
    end
    else if (wr_fire)
    begin
      bvalid_out <= 1'b1;
      bresp_out <= (aw_addr[ADDR_W-1:2] == REG_CTRL[ADDR_W-1:2]) ? RESP_OKAY : RESP_SLVERR;
    end
    else if (bready_in)
      bvalid_out <= 1'b0;
  end

  // Control register, byte lanes honoured; request bit self-clears
  always_ff @(posedge clk_in)
  begin
    if (rst_in)
      ctrl <= CTRL_RESET;
    else if (wr_fire && aw_addr[ADDR_W-1:2] == REG_CTRL[ADDR_W-1:2])
    begin
      for (int b = 0; b < 4; b++)
        if (w_strb[b])
          ctrl[8*b +: 8] <= w_data[8*b +: 8] & CTRL_MASK[8*b +: 8];
    end
  end

  // R8 status request; set wins over clear
  always_ff @(posedge clk_in)
  begin
    if (rst_in)
      stat_pend <= 1'b0;
    else if (wr_fire && aw_addr[ADDR_W-1:2] == REG_CTRL[ADDR_W-1:2] && w_strb[1]
             && w_data[CTRL_STREQ] && ctrl[CTRL_STINJ])
      stat_pend <= 1'b1;
    else if (rx_st == RXS_STAT)
      stat_pend <= 1'b0;
  end

  // Read channel; unmapped words read zero with an error
  always_ff @(posedge clk_in)
  begin
    if (rst_in)
    begin
      arready_out <= 1'b0;
      rvalid_out <= 1'b0;
      rdata_out <= '0;
      rresp_out <= RESP_OKAY;
    end
    else if (arready_out && arvalid_in)
    begin
      arready_out <= 1'b0;
      rvalid_out <= 1'b1;
      rresp_out <= RESP_OKAY;
      unique case (araddr_in[ADDR_W-1:2])
        REG_CTRL[ADDR_W-1:2]: rdata_out <= ctrl;
        REG_STATUS[ADDR_W-1:2]: rdata_out <= {27'h0, rx_st == RXS_STAT, src_rec,
                                              md_tx_en_out, rx_dv_out, crs_out};
        REG_TXLAT[ADDR_W-1:2]: rdata_out <= {24'h0, tx_lat};
        REG_RXLAT[ADDR_W-1:2]: rdata_out <= {24'h0, rx_lat};
        default:
        begin
          rdata_out <= '0;
          rresp_out <= RESP_SLVERR;
        end
      endcase
    end
    else if (rvalid_out && rready_in)
      rvalid_out <= 1'b0;
    else if (!rvalid_out)
      arready_out <= 1'b1;
  end

  // Pin inputs cross into the system clock domain
  mdl_sync #(.W(6)) u_tx_sync (
    .clk_in(clk_in),
    .rst_in(rst_in),
    .d_in({tx_clk_in, tx_en_in, txd_in}),
    .q_out(tx_s)
  );

  mdl_sync #(.W(6)) u_rx_sync (
    .clk_in(clk_in),
    .rst_in(rst_in),
    .d_in({rec_lock_in, md_rx_act_in, md_rxd_in}),
    .q_out(rx_s)
  );

  // Latencies in cycles; one cycle is one bit at 100 Mb/s
  always_comb
  begin
    // R12 100 Mb/s counted in 10 ns bits
    // R2 one-step replaces base
    // R3 control frame depth
    // R20 increments simply add
    next_tx_lat = LAT_W'((ctrl[CTRL_ONESTEP] ? TX_ONESTEP_BITS : TX_BASE_BITS) * CYC100
                  + (ctrl[CTRL_PCF] ? PCF_UNIT_BITS * CYC100
                  * int'(ctrl[CTRL_DEPTH_LSB +: 4]) : 0));
    // R6 receive base latency
    // R7 timestamp insertion
    next_rx_lat = LAT_W'((fx ? RXD_FX_BITS : RXD_TX_BITS) * CYC100
                  + (ctrl[CTRL_RXTS] ? RX_TS_BITS * CYC100 : 0) + int'(rx_extra));
    next_dv_lat = next_rx_lat;
    // R5 carrier on delay
    next_on_lat = LAT_W'((fx ? CRS_ON_FX_BITS : CRS_ON_TX_BITS) * CYC100);
    // R9 carrier off delay
    next_off_lat = LAT_W'((fx ? CRS_OFF_FX_BITS : CRS_OFF_TX_BITS) * CYC100);
    if (spd10)
    begin
      // R13 10 Mb/s counted in 100 ns bits
      // R14 start 3.5 bits
      next_tx_lat = LAT_W'(TX10_CYC);
      // R18 data latency
      next_rx_lat = LAT_W'(RXD10_BITS * CYC10 + int'(rx_extra));
      // R17 valid latency
      next_dv_lat = LAT_W'(RXDV10_BITS * CYC10 + int'(rx_extra));
      // R16 carrier on
      next_on_lat = LAT_W'(CRS10_ON_CYC);
      // R19 carrier off bound
      next_off_lat = LAT_W'(CRS10_OFF_CYC);
    end
  end

  assign tx_quiet = !tx_hold[4] && !tx_q0[4] && !md_tx_en_out;
  assign rx_quiet = !rx_s[4] && !rx_q0[4] && !rx_q1[4] && !crs_out && rx_st != RXS_STAT;

  // R20 new settings take effect only between frames
  always_ff @(posedge clk_in)
  begin
    if (rst_in)
    begin
      tx_lat <= LAT_W'(TX_BASE_BITS * CYC100);
      rx_lat <= LAT_W'(RXD_TX_BITS * CYC100);
      dv_lat <= LAT_W'(RXD_TX_BITS * CYC100);
      on_lat <= LAT_W'(CRS_ON_TX_BITS * CYC100);
      off_lat <= LAT_W'(CRS_OFF_TX_BITS * CYC100);
    end
    else
    begin
      if (tx_quiet)
        tx_lat <= next_tx_lat;
      if (rx_quiet || (rx_st == RXS_STAT && !act_d))
      begin
        rx_lat <= next_rx_lat;
        dv_lat <= next_dv_lat;
        on_lat <= next_on_lat;
        off_lat <= next_off_lat;
      end
    end
  end

  // Transmit clock edge finder
  always_ff @(posedge clk_in)
  begin
    if (rst_in)
      tclk_d <= 1'b0;
    else
      tclk_d <= tx_s[5];
  end

  // R11 falling edge at 10 Mb/s, rising at 100 Mb/s
  assign tx_edge = spd10 ? (tclk_d && !tx_s[5]) : (!tclk_d && tx_s[5]);

  // Sampled enable and nibble, held between edges
  always_ff @(posedge clk_in)
  begin
    if (rst_in)
      tx_hold <= '0;
    else if (tx_edge)
      tx_hold <= tx_s[4:0];
  end

  // R1 start and R4 end share one delay
  mdl_delay #(.W(5)) u_tx_line (
    .clk_in(clk_in),
    .rst_in(rst_in),
    .d_in(tx_hold),
    .tap0_in(tx_lat),
    .tap1_in(tx_lat),
    .q0_out(tx_q0),
    .q1_out()
  );

  // Medium transmit outputs
  always_ff @(posedge clk_in)
  begin
    if (rst_in)
    begin
      md_tx_en_out <= 1'b0;
      md_txd_out <= '0;
    end
    else
    begin
      md_tx_en_out <= tx_q0[4];
      md_txd_out <= tx_q0[3:0];
    end
  end

  // R15 hold line high after the last bit, either value
  always_ff @(posedge clk_in)
  begin
    if (rst_in)
    begin
      eop_cnt <= '0;
      md_tx_eop_out <= 1'b0;
    end
    else
    begin
      if (spd10 && md_tx_en_out && !tx_q0[4])
        eop_cnt <= 6'(EOP_HOLD_CYC);
      else if (eop_cnt != 6'h00)
        eop_cnt <= eop_cnt - 6'h01;
      md_tx_eop_out <= (spd10 && md_tx_en_out && !tx_q0[4]) || eop_cnt > 6'h01;
    end
  end

  // Carrier path: on and off taps from the activity level
  mdl_delay #(.W(1)) u_crs_line (
    .clk_in(clk_in),
    .rst_in(rst_in),
    .d_in(rx_s[4]),
    .tap0_in(on_lat),
    .tap1_in(off_lat),
    .q0_out(crs_on_q),
    .q1_out(crs_off_q)
  );

  // R5 rises on early tap, R9 falls on late tap
  always_ff @(posedge clk_in)
  begin
    if (rst_in)
      crs_out <= 1'b0;
    else
      crs_out <= crs_on_q || crs_off_q;
  end

  // Receive data line: first tap data, second tap valid
  mdl_delay #(.W(5)) u_rx_line (
    .clk_in(clk_in),
    .rst_in(rst_in),
    .d_in(rx_s[4:0]),
    .tap0_in(rx_lat),
    .tap1_in(dv_lat),
    .q0_out(rx_q0),
    .q1_out(rx_q1)
  );

  // R8 frame arriving during a status frame sets rx_extra as rx_lat last reloads; it does not wait
  always_ff @(posedge clk_in)
  begin
    if (rst_in)
    begin
      act_d <= 1'b0;
      rx_extra <= '0;
    end
    else
    begin
      act_d <= rx_s[4];
      if (rx_st == RXS_STAT && rx_s[4] && !act_d)
        rx_extra <= LAT_W'(stat_cnt) + 8'h01;
      else if (rx_quiet)
        rx_extra <= '0;
    end
  end

  // Receive output, shared with status frames
  always_ff @(posedge clk_in)
  begin
    if (rst_in)
    begin
      rx_st <= RXS_IDLE;
      stat_cnt <= '0;
      rx_dv_out <= 1'b0;
      rxd_out <= '0;
    end
    else
    begin
      unique case (rx_st)
        RXS_IDLE:
        begin
          rx_dv_out <= rx_q1[4];
          rxd_out <= rx_q0[3:0];
          if (stat_pend && rx_quiet)
          begin
            rx_st <= RXS_STAT;
            stat_cnt <= 7'(STATUS_LEN_CYC);
          end
          else if (rx_q1[4])
            rx_st <= RXS_FRAME;
        end
        RXS_STAT:
        begin
          rx_dv_out <= 1'b1;
          rxd_out <= STATUS_NIB;
          stat_cnt <= stat_cnt - 7'h01;
          if (stat_cnt == 7'h01)
            rx_st <= RXS_IDLE;
        end
        RXS_FRAME:
        begin
          rx_dv_out <= rx_q1[4];
          rxd_out <= rx_q0[3:0];
          if (!rx_q1[4])
            rx_st <= RXS_IDLE;
        end
        default:
          rx_st <= RXS_IDLE;
      endcase
    end
  end

  // R10 source switch stretches one phase
  always_ff @(posedge clk_in)
  begin
    if (rst_in)
    begin
      rx_clk_out <= 1'b0;
      ph_cnt <= '0;
      half_cur <= 5'(HALF100_CYC);
      src_rec <= 1'b0;
    end
    else if (ph_cnt >= half_cur - 5'h01)
    begin
      ph_cnt <= '0;
      half_cur <= spd10 ? 5'(HALF10_CYC) : 5'(HALF100_CYC);
      if (src_rec != rx_s[5])
        src_rec <= rx_s[5];
      else
        rx_clk_out <= !rx_clk_out;
    end
    else
      ph_cnt <= ph_cnt + 5'h01;
  end
endmodule : mdl_datapath

/* verilog/mdl_pkg.sv */
// Constants shared by the MII datapath latency block
package mdl_pkg;
  // Clock and bit times
  localparam int CLK_NS = 10;
  localparam int BIT100_NS = 10;
  localparam int BIT10_NS = 100;
  localparam int CYC100 = BIT100_NS / CLK_NS;
  localparam int CYC10 = BIT10_NS / CLK_NS;
  // 100 Mb/s latencies in bit times
  localparam int TX_BASE_BITS = 5;
  localparam int TX_ONESTEP_BITS = 9;
  localparam int PCF_UNIT_BITS = 8;
  localparam int CRS_ON_TX_BITS = 20;
  localparam int CRS_ON_FX_BITS = 10;
  localparam int CRS_OFF_TX_BITS = 24;
  localparam int CRS_OFF_FX_BITS = 14;
  localparam int RXD_TX_BITS = 24;
  localparam int RXD_FX_BITS = 14;
  localparam int RX_TS_BITS = 40;
  // 10 Mb/s latencies; start delay is in tenths of a bit
  localparam int TX10_TENTHS = 35;
  localparam int EOP_HOLD_NS = 300;
  localparam int CRS10_ON_NS = 630;
  localparam int CRS10_OFF_MAX_NS = 1000;
  localparam int RXDV10_BITS = 10;
  localparam int RXD10_BITS = 8;
  localparam int TX10_CYC = (TX10_TENTHS * BIT10_NS + 10 * CLK_NS - 1) / (10 * CLK_NS);
  localparam int EOP_HOLD_CYC = (EOP_HOLD_NS + CLK_NS - 1) / CLK_NS;
  localparam int CRS10_ON_CYC = (CRS10_ON_NS + CLK_NS - 1) / CLK_NS;
  localparam int CRS10_OFF_CYC = CRS10_OFF_MAX_NS / CLK_NS;
  // Receive clock half periods
  localparam int MII100_HALF_NS = 20;
  localparam int MII10_HALF_NS = 200;
  localparam int HALF100_CYC = MII100_HALF_NS / CLK_NS;
  localparam int HALF10_CYC = MII10_HALF_NS / CLK_NS;
  // Status frame length and pattern
  localparam int STATUS_LEN_CYC = 64;
  localparam logic [3:0] STATUS_NIB = 4'h5;
  // Delay line geometry
  localparam int LAT_W = 8;
  localparam int DEPTH = 256;
  // Register map
  localparam int ADDR_W = 8;
  localparam logic [ADDR_W-1:0] REG_CTRL = 8'h00;
  localparam logic [ADDR_W-1:0] REG_STATUS = 8'h04;
  localparam logic [ADDR_W-1:0] REG_TXLAT = 8'h08;
  localparam logic [ADDR_W-1:0] REG_RXLAT = 8'h0c;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
  localparam logic [31:0] CTRL_MASK = 32'h0000_03ff;
  localparam int CTRL_SPD10 = 0;
  localparam int CTRL_FX = 1;
  localparam int CTRL_ONESTEP = 2;
  localparam int CTRL_PCF = 3;
  localparam int CTRL_DEPTH_LSB = 4;
  localparam int CTRL_RXTS = 8;
  localparam int CTRL_STINJ = 9;
  localparam int CTRL_STREQ = 10;
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;
  // Receive output path states
  typedef enum logic [2:0] {
    RXS_IDLE = 3'b001,
    RXS_STAT = 3'b010,
    RXS_FRAME = 3'b100
  } mdl_rxs_t;
endpackage : mdl_pkg

/* verilog/mdl_sync.sv */
// Two flip-flop level synchroniser
module mdl_sync #(
  parameter int W = 1
) (
  input wire logic clk_in, // System clock
  input wire logic rst_in, // Synchronous reset
  input wire logic [W-1:0] d_in, // Asynchronous levels
  output logic [W-1:0] q_out // Synchronised levels
);
  logic [W-1:0] meta;

  // First stage feeds only the second
  always_ff @(posedge clk_in)
  begin
    if (rst_in)
    begin
      meta <= '0;
      q_out <= '0;
    end
    else
    begin
      meta <= d_in;
      q_out <= meta;
    end
  end
endmodule : mdl_sync

/* verilog/mdl_delay.sv */
// Two-tap delay line counted in clock cycles
module mdl_delay
  import mdl_pkg::*;
#(
  parameter int W = 1
) (
  input wire logic clk_in, // System clock
  input wire logic rst_in, // Synchronous reset
  input wire logic [W-1:0] d_in, // Value entering the line
  input wire logic [LAT_W-1:0] tap0_in, // Delay of first tap
  input wire logic [LAT_W-1:0] tap1_in, // Delay of second tap
  output logic [W-1:0] q0_out, // First tap, registered
  output logic [W-1:0] q1_out // Second tap, registered
);
  logic [W-1:0] mem [DEPTH];
  logic [LAT_W-1:0] wp;
  logic [LAT_W-1:0] fill;

  // Memory has no reset; writes every cycle
  always_ff @(posedge clk_in)
  begin
    mem[wp] <= d_in;
  end

  // Fill count masks stale words after reset
  always_ff @(posedge clk_in)
  begin
    if (rst_in)
    begin
      wp <= '0;
      fill <= '0;
      q0_out <= '0;
      q1_out <= '0;
    end
    else
    begin
      wp <= wp + 8'h01;
      if (fill != 8'hff)
        fill <= fill + 8'h01;
      q0_out <= (fill >= tap0_in) ? mem[wp - tap0_in] : '0;
      q1_out <= (fill >= tap1_in) ? mem[wp - tap1_in] : '0;
    end
  end
endmodule : mdl_delay

/* test/mdl_datapath_asserts.sv */
// Port-level checks for the MII datapath latency block
module mdl_datapath_asserts
  import mdl_pkg::*;
(
  input wire logic clk_in, // System clock
  input wire logic rst_in, // Synchronous reset
  input wire logic awvalid_in, // Write address valid
  input wire logic awready_out, // Write address ready
  input wire logic wvalid_in, // Write data valid
  input wire logic wready_out, // Write data ready
  input wire logic [1:0] bresp_out, // Write response
  input wire logic bvalid_out, // Write response valid
  input wire logic bready_in, // Write response ready
  input wire logic arvalid_in, // Read address valid
  input wire logic arready_out, // Read address ready
  input wire logic [31:0] rdata_out, // Read data
  input wire logic [1:0] rresp_out, // Read response
  input wire logic rvalid_out, // Read data valid
  input wire logic rready_in, // Read data ready
  input wire logic rx_clk_out, // Receive clock
  input wire logic crs_out, // Carrier sense
  input wire logic md_tx_eop_out, // End-of-packet high hold
  input wire logic md_rx_act_in // Medium receive activity
);
  timeunit 1ns;
  timeprecision 100ps;
  int eop_cnt;
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (rst_in);
  // Cycles the end-of-packet hold has stood
  always_ff @(posedge clk_in)
  begin
    if (rst_in || !md_tx_eop_out)
      eop_cnt <= 0;
    else
      eop_cnt <= eop_cnt + 1;
  end
  a_bresp_follows: assert property ((awvalid_in && awready_out && wvalid_in && wready_out)
    |=> ##1 bvalid_out) else $error("write response late");
  a_bresp_holds: assert property ((bvalid_out && !bready_in) |=> (bvalid_out && $stable(bresp_out)))
    else $error("write response dropped");
  a_rdata_follows: assert property ((arvalid_in && arready_out) |=> rvalid_out)
    else $error("read data late");
  a_rdata_holds: assert property ((rvalid_out && !rready_in)
    |=> (rvalid_out && $stable(rdata_out) && $stable(rresp_out))) else $error("read data moved");
  a_write_refused: assert property (bvalid_out |-> (!awready_out && !wready_out))
    else $error("write taken while response pending");
  a_read_refused: assert property (rvalid_out |-> !arready_out)
    else $error("read taken while data pending");
  a_rxclk_phase: assert property ($changed(rx_clk_out) |=> $stable(rx_clk_out))
    else $error("receive clock phase too short");
  a_eop_hold: assert property ($fell(md_tx_eop_out) |-> eop_cnt == EOP_HOLD_CYC)
    else $error("end-of-packet hold length wrong");
  a_crs_cause: assert property ($rose(crs_out) |-> $past(md_rx_act_in, 12))
    else $error("carrier sense without earlier activity");
  a_crs_drop: assert property ($fell(md_rx_act_in) |-> ##[1:105] !crs_out)
    else $error("carrier sense held too long");
endmodule : mdl_datapath_asserts

/* test/mdl_mac_model.sv */
// Controller-side model that sends one MII frame of nibbles
module mdl_mac_model (
  input wire logic go_in, // Start one frame
  input wire logic [7:0] len_in, // Frame length in nibbles
  output logic tx_clk_out = 1'b0, // Transmit clock, still between frames
  output logic tx_en_out = 1'b0, // Transmit enable
  output logic [3:0] txd_out = 4'h0, // Transmit nibble
  output logic busy_out = 1'b0 // Frame in progress
);
  timeunit 1ns;
  timeprecision 100ps;
  int k;
  // Three spare clocks let either edge sample the frame end
  always @(posedge go_in)
  begin
    busy_out = 1'b1;
    #3;
    for (k = 0; k <= len_in + 2; k++)
    begin
      tx_clk_out = 1'b1;
      #20;
      // data moves after the rising edge
      tx_en_out = (k < len_in);
      txd_out = (k < len_in) ? 4'(k + 1) : ~txd_out;
      #42.5;
      tx_clk_out = 1'b0;
      #62.5;
    end
    busy_out = 1'b0;
  end
endmodule : mdl_mac_model

/* test/mdl_datapath_tb.sv */
// Self-checking bench for the MII datapath latency block
module mdl_datapath_tb
  import mdl_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk_in = 1'b0;
  logic rst_in = 1'b1;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00, len = 8'h14;
  logic [31:0] wdata = 32'h0, rdata;
  logic [3:0] wstrb = 4'h0, md_rxd = 4'h0, txd, rxd, md_txd;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic md_rx_act = 1'b0, rec_lock = 1'b0, go = 1'b0, spd10 = 1'b0, en_seen = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, tx_clk, tx_en, rx_clk, rx_dv, crs;
  logic md_tx_en, md_eop, busy;
  logic [1:0] bresp, rresp;
  int n_fail = 0, checks = 0, n_stat = 0;
  realtime t_ref = 0.0;
  always #5 clk_in = ~clk_in;
  mdl_datapath DUT (.clk_in(clk_in), .rst_in(rst_in), .awaddr_in(awaddr), .awvalid_in(awvalid),
    .awready_out(awready), .wdata_in(wdata), .wstrb_in(wstrb), .wvalid_in(wvalid),
    .wready_out(wready), .bresp_out(bresp), .bvalid_out(bvalid), .bready_in(bready),
    .araddr_in(araddr), .arvalid_in(arvalid), .arready_out(arready), .rdata_out(rdata),
    .rresp_out(rresp), .rvalid_out(rvalid), .rready_in(rready), .tx_clk_in(tx_clk),
    .tx_en_in(tx_en), .txd_in(txd), .rx_clk_out(rx_clk), .rx_dv_out(rx_dv), .rxd_out(rxd),
    .crs_out(crs), .md_tx_en_out(md_tx_en), .md_txd_out(md_txd), .md_tx_eop_out(md_eop),
    .md_rx_act_in(md_rx_act), .md_rxd_in(md_rxd), .rec_lock_in(rec_lock));
  mdl_mac_model u_mac (.go_in(go), .len_in(len), .tx_clk_out(tx_clk), .tx_en_out(tx_en),
    .txd_out(txd), .busy_out(busy));
  // Time of the sampling edge that first sees a new enable
  always @(tx_clk)
  begin
    if (tx_clk !== spd10 && tx_en !== en_seen)
    begin
      t_ref = $realtime;
      en_seen = tx_en;
    end
  end
  // Status frame cycles seen
  always @(posedge clk_in)
  begin
    if (rx_dv === 1'b1 && rxd === STATUS_NIB)
      n_stat <= n_stat + 1;
  end
  task complete_run;
    $display("checks %0d mismatches %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : complete_run
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e)
    begin
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
      n_fail++;
    end
  endtask : chk
  // Sync stages leave a three-cycle window
  task automatic chk_rng(input string nm, input int lo, input int g);
    checks++;
    if (g < lo || g > lo + 2)
    begin
      $display("[FAIL] %s expected %0d to %0d seen %0d", nm, lo, lo + 2, g);
      n_fail++;
    end
  endtask : chk_rng
  task automatic hang(input logic t);
    if (t)
    begin
      $display("[FAIL] wait expected done seen timeout");
      n_fail++;
      complete_run();
    end
  endtask : hang
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
    input logic [1:0] er);
    bit done = 1'b0;
    awaddr <= a;
    wdata <= d;
    wstrb <= s;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (int k = 0; k < 50 && !done; k++)
    begin
      @(posedge clk_in);
      if (awvalid && awready)
        awvalid <= 1'b0;
      if (wvalid && wready)
        wvalid <= 1'b0;
      if (bvalid === 1'b1)
      begin
        done = 1'b1;
        bready <= 1'b0;
        chk("bresp", 32'(er), 32'(bresp));
      end
    end
    hang(!done);
    @(posedge clk_in);
  endtask : axi_wr
  task automatic axi_rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
    bit done = 1'b0;
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (int k = 0; k < 50 && !done; k++)
    begin
      @(posedge clk_in);
      if (arvalid && arready)
        arvalid <= 1'b0;
      if (rvalid === 1'b1)
      begin
        done = 1'b1;
        rready <= 1'b0;
        chk("rdata", e, rdata);
        chk("rresp", 32'(er), 32'(rresp));
      end
    end
    hang(!done);
    @(posedge clk_in);
  endtask : axi_rd
  task automatic md_edge(input logic lvl, input int tap);
    for (int k = 0; k < 600; k++)
    begin
      @(posedge clk_in);
      if (md_tx_en === lvl)
        break;
    end
    hang(md_tx_en !== lvl);
    chk_rng("md_tx_en delay", tap + 4, $rtoi($ceil(($realtime - t_ref) / 10.0)) - 1);
    if (lvl)
      chk("md_txd first", 32'h1, 32'(md_txd));
  endtask : md_edge
  task automatic tx_frame(input logic [31:0] ctrl, input int tap);
    spd10 = ctrl[CTRL_SPD10];
    axi_wr(REG_CTRL, ctrl, 4'hf, RESP_OKAY);
    axi_rd(REG_TXLAT, 32'(tap), RESP_OKAY);
    go <= 1'b1;
    md_edge(1'b1, tap);
    md_edge(1'b0, tap);
    for (int k = 0; k < 400; k++)
    begin
      @(posedge clk_in);
      if (busy === 1'b0)
        break;
    end
    hang(busy !== 1'b0);
    go <= 1'b0;
    // Let the end-of-packet hold finish first
    repeat (EOP_HOLD_CYC + 10) @(posedge clk_in);
  endtask : tx_frame
  task automatic rx_frame(input logic [31:0] ctrl, input int on, input int off, input int dv);
    int t_on = 0, t_off = 0, t_dv = 0;
    axi_wr(REG_CTRL, ctrl, 4'hf, RESP_OKAY);
    for (int k = 0; k < 300; k++)
    begin
      md_rx_act <= (k < 120);
      md_rxd <= 4'(k + 1);
      rec_lock <= k[6];
      @(posedge clk_in);
      if (crs === 1'b1 && t_on == 0)
        t_on = k;
      if (rx_dv === 1'b1 && t_dv == 0)
      begin
        t_dv = k;
        chk("rxd first", 32'(4'(ctrl[CTRL_SPD10] ? 1 + (RXDV10_BITS - RXD10_BITS) * CYC10 : 1)),
          32'(rxd));
      end
      if (crs === 1'b0 && t_on != 0 && t_off == 0)
        t_off = k - 120;
    end
    chk_rng("crs on", on + 3, t_on);
    chk_rng("crs off", off + 3, t_off);
    chk_rng("rx_dv on", dv + 3, t_dv);
  endtask : rx_frame
  initial
  begin
    repeat (4) @(posedge clk_in);
    rst_in <= 1'b0;
    repeat (2) @(posedge clk_in);
    // Reset value, unmapped place and byte lanes
    axi_rd(REG_CTRL, CTRL_RESET, RESP_OKAY);
    axi_rd(8'h10, 32'h0, RESP_SLVERR);
    axi_wr(8'h10, 32'h1, 4'hf, RESP_SLVERR);
    axi_wr(REG_CTRL, 32'h338, 4'h1, RESP_OKAY);
    axi_rd(REG_CTRL, 32'h38, RESP_OKAY);
    tx_frame(32'h0, TX_BASE_BITS);
    tx_frame(32'h4, TX_ONESTEP_BITS);
    tx_frame(32'h38, TX_BASE_BITS + 3 * PCF_UNIT_BITS);
    tx_frame(32'h3c, TX_ONESTEP_BITS + 3 * PCF_UNIT_BITS);
    tx_frame(32'h1, TX10_CYC);
    rx_frame(32'h0, CRS_ON_TX_BITS, CRS_OFF_TX_BITS, RXD_TX_BITS);
    rx_frame(32'h2, CRS_ON_FX_BITS, CRS_OFF_FX_BITS, RXD_FX_BITS);
    rx_frame(32'h100, CRS_ON_TX_BITS, CRS_OFF_TX_BITS, RXD_TX_BITS + RX_TS_BITS);
    rx_frame(32'h102, CRS_ON_FX_BITS, CRS_OFF_FX_BITS, RXD_FX_BITS + RX_TS_BITS);
    rx_frame(32'h1, CRS10_ON_CYC, CRS10_OFF_CYC, RXDV10_BITS * CYC10);
    axi_wr(REG_CTRL, 32'h200, 4'hf, RESP_OKAY);
    n_stat = 0;
    axi_wr(REG_CTRL, 32'h600, 4'hf, RESP_OKAY);
    repeat (200) @(posedge clk_in);
    chk("status frame cycles", STATUS_LEN_CYC, n_stat);
    axi_rd(REG_CTRL, 32'h200, RESP_OKAY);
    complete_run();
  end
endmodule : mdl_datapath_tb
bind mdl_datapath mdl_datapath_asserts u_chk (.clk_in, .rst_in, .awvalid_in, .awready_out,
  .wvalid_in, .wready_out, .bresp_out, .bvalid_out, .bready_in, .arvalid_in, .arready_out,
  .rdata_out, .rresp_out, .rvalid_out, .rready_in, .rx_clk_out, .crs_out, .md_tx_eop_out,
  .md_rx_act_in);
